// ### logic/fcs_addr_decode.sv
// Address field decoder for command writes
`timescale 1ns/1ps
module fcs_addr_decode
  import fcs_pkg::*;
(
  fcs_dec_if.dec d
);
  logic [4:0] swap_raw;
  logic [4:0] swap_off;

  assign d.in_window = d.addr[TAG_HI:TAG_LO] == WIN_TAG; // RL3
  assign d.bank_low = ~d.addr[BANK_BIT];
  assign d.id_sel = d.addr[IDSEL_HI:IDSEL_LO]; // RL7
  assign d.page_addr = d.addr[PGADDR_HI:PGADDR_LO]; // RL9
  assign d.block_num = d.addr[BLK_HI:BLK_LO]; // RL12
  assign d.page_num = d.addr[PGNUM_HI:PGNUM_LO]; // RL13
  assign d.area_sel = d.addr[BANK_BIT]; // RL11
  assign d.pbit_idx = d.addr[PBIT_HI:PBIT_LO]; // RL16
  assign d.pbit_ok = d.in_window && d.bank_low
    && (d.addr[PBIT_HI:PBIT_LO] <= PBIT_LAST); // RL16

  // Swap selector is an offset pattern, not a plain index
  assign swap_raw = d.addr[SWAP_HI:SWAP_LO];
  assign swap_off = swap_raw - SWAP_BASE; // RL19
  assign d.swap_idx = swap_off[3:0];
  assign d.swap_ok = d.in_window && d.bank_low && d.addr[SWAP_SEL_BIT]
    && (d.addr[SWAP_ZERO_HI:SWAP_ZERO_LO] == 2'h0)
    && (swap_raw >= SWAP_BASE) && (swap_off < SWAP_COUNT); // RL18 RL19
endmodule

// ### logic/fcs_dec_if.sv
// Carrier between the sequencer and its address field decoder
`timescale 1ns/1ps
interface fcs_dec_if;
  logic [31:0] addr;
  logic in_window;
  logic bank_low;
  logic [1:0] id_sel;
  logic [15:0] page_addr;
  logic [5:0] block_num;
  logic [6:0] page_num;
  logic area_sel;
  logic pbit_ok;
  logic [7:0] pbit_idx;
  logic swap_ok;
  logic [3:0] swap_idx;
  modport dec (input addr, output in_window, bank_low, id_sel, page_addr,
    block_num, page_num, area_sel, pbit_ok, pbit_idx, swap_ok, swap_idx);
  modport use_side (output addr, input in_window, bank_low, id_sel,
    page_addr, block_num, page_num, area_sel, pbit_ok, pbit_idx, swap_ok,
    swap_idx);
endinterface

// ### logic/fcs_pkg.sv
// Constants, types and decode helpers of the flash command sequence decoder
package fcs_pkg;
  // ****************************************************************
  // Address layout of a command write
  // ****************************************************************
  localparam logic [11:0] WIN_TAG = 12'h5E0;
  localparam int TAG_HI = 31;
  localparam int TAG_LO = 20;
  localparam int BANK_BIT = 19;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 9;
  localparam logic [6:0] CMD_FIELD_A = 7'h2A;
  localparam logic [6:0] CMD_FIELD_B = 7'h55;
  localparam int IDSEL_HI = 15;
  localparam int IDSEL_LO = 14;
  localparam int PGADDR_HI = 18;
  localparam int PGADDR_LO = 3;
  localparam int BLK_HI = 18;
  localparam int BLK_LO = 13;
  localparam int PGNUM_HI = 18;
  localparam int PGNUM_LO = 12;
  localparam int PBIT_HI = 11;
  localparam int PBIT_LO = 4;
  localparam logic [7:0] PBIT_LAST = 8'h26;
  localparam int SWAP_SEL_BIT = 11;
  localparam int SWAP_ZERO_HI = 10;
  localparam int SWAP_ZERO_LO = 9;
  localparam int SWAP_HI = 8;
  localparam int SWAP_LO = 4;
  localparam logic [4:0] SWAP_BASE = 5'h08;
  localparam logic [4:0] SWAP_COUNT = 5'h0B;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] PROG_WORDS = 2'h3;

  // ****************************************************************
  // Data bytes and ID select codes
  // ****************************************************************
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_IDREAD = 8'h90;
  localparam logic [7:0] D_IDSEL = 8'h00;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_PBIT = 8'h9A;
  localparam logic [7:0] D_PERASE = 8'h6A;
  localparam logic [7:0] SEL_CHIP = 8'h10;
  localparam logic [7:0] SEL_AREA = 8'h20;
  localparam logic [7:0] SEL_BLOCK = 8'h30;
  localparam logic [7:0] SEL_PAGE = 8'h40;
  localparam logic [1:0] IDC_MFR = 2'h0;
  localparam logic [1:0] IDC_DEV = 2'h1;
  localparam logic [1:0] IDC_MACRO = 2'h3;

  typedef enum logic [9:0] {
    ST_READ = 10'h001, ST_U1 = 10'h002, ST_U2 = 10'h004,
    ST_ID = 10'h008, ST_TARGET = 10'h010, ST_PROG = 10'h020,
    ST_E1 = 10'h040, ST_E2 = 10'h080, ST_E3 = 10'h100,
    ST_C4 = 10'h200
  } fcs_state_e;

  typedef enum logic [2:0] {
    OP_PROG = 3'h0, OP_CHIP = 3'h1, OP_AREA = 3'h2, OP_BLOCK = 3'h3,
    OP_PAGE = 3'h4, OP_PBIT_PROG = 3'h5, OP_PBIT_ERASE = 3'h6,
    OP_SWAP = 3'h7
  } fcs_op_e;

  function automatic logic fcs_at(input logic [31:0] a,
                                  input logic [6:0] f);
    fcs_at = (a[TAG_HI:TAG_LO] == WIN_TAG) && (a[CMD_HI:CMD_LO] == f);
  endfunction
endpackage

// ### logic/fcs_sequencer.sv
// Flash command sequence decoder: unlock sequences to operation requests
// Summary of operation
// [RL1] Command cycles are 32-bit word writes; only the low data byte counts.
// [RL2] Issuer drives address bit 19 to pick lower or upper region.
// [RL3] Command writes carry 0x5E0 in bits 31:20, command field in 15:9.
// [RL4] One write of 0xF0 in window with bit 19 low is read/reset.
// [RL5] Multi-cycle commands open with AA, 55 unlock writes then command byte.
// [RL6] ID read: byte 0x90, select write of 0x00, then any flash read.
// [RL7] Select address bits 15:14 pick manufacturer, device or macro code.
// [RL8] Program: byte 0xA0, then words at ascending addresses.
// [RL9] Program page location comes from address bits 18:3.
// [RL10] Erase: AA,55,80,AA,55 then selector 10,20,30 or 40.
// [RL11] Area erase takes the region from address bit 19.
// [RL12] Block erase takes block number from address bits 18:13.
// [RL13] Page erase takes page number from address bits 18:12.
// [RL14] Any address inside the target block or area is accepted.
// [RL15] Protect bit program: byte 0x9A, fourth write 0x9A sets one bit.
// [RL16] Address bits 11:4 pick page bits of block 0, then blocks.
// [RL17] Protect bit erase: byte 0x6A, fourth write 0x6A, bit 19 low.
// [RL18] Swap ends with 0x9A to address with bit 11 high, 10:9 low.
// [RL19] Address bits 8:4 from 01000 upward pick one of eleven swap bits.
// [RL20] Issuer checks oscillator stable flag before programming after deep stop.
// [RL21] Read/reset returns to read mode and cancels a partial sequence.
// [RL22] ID read mode holds until read/reset; select may repeat. Code also leaves it on any other word write and while op_busy is high.
// [RL23] New sequences are ignored while an operation runs.
// [RL24] Protected erase target is skipped and read mode resumes.
// [RL25] A mismatching write abandons the sequence back to read mode.
// [RL26] Swap and protect program are told apart by the fourth address.
`timescale 1ns/1ps
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter logic [7:0] ID_CODE_MFR = 8'h11,   // Arbitrary value
  parameter logic [7:0] ID_CODE_DEV = 8'h22,   // Arbitrary value
  parameter logic [7:0] ID_CODE_MACRO = 8'h33  // Arbitrary value
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic bus_word,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic op_busy,
  input wire logic target_protected,
  output logic [7:0] code_rdata,
  output logic code_rvalid,
  output logic id_mode,
  output logic check_pending,
  output logic op_start,
  output logic op_skip,
  output fcs_pkg::fcs_op_e op_kind,
  output logic [15:0] page_addr,
  output logic [5:0] block_num,
  output logic [6:0] page_num,
  output logic area_sel,
  output logic [7:0] pbit_idx,
  output logic [3:0] swap_idx,
  output logic prog_word_valid,
  output logic [31:0] prog_word
);
  import fcs_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  fcs_dec_if dif ();
  assign dif.addr = bus_addr;
  fcs_addr_decode u_dec (
    .d (dif.dec)
  );

  fcs_state_e state;
  fcs_state_e next_state;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [1:0] id_sel;
  logic [1:0] next_id_sel;
  logic [31:0] last_addr;
  logic [31:0] next_last_addr;
  logic [1:0] word_cnt;
  logic [1:0] next_word_cnt;
  logic chk;
  logic next_chk;
  logic next_op_start;
  logic next_op_skip;
  fcs_op_e next_op_kind;
  logic [15:0] next_page_addr;
  logic [5:0] next_block_num;
  logic [6:0] next_page_num;
  logic next_area_sel;
  logic [7:0] next_pbit_idx;
  logic [3:0] next_swap_idx;
  logic next_word_valid;
  logic [31:0] next_prog_word;
  logic [7:0] next_code;
  logic next_code_valid;

  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic reset_cmd;
  logic at_a;
  logic at_b;

  // Narrow writes never advance a sequence
  assign wr = bus_req && bus_we && bus_word; // RL1
  assign rd = bus_req && !bus_we;
  assign wbyte = bus_wdata[7:0]; // RL1
  assign at_a = fcs_at(bus_addr, CMD_FIELD_A); // RL3
  assign at_b = fcs_at(bus_addr, CMD_FIELD_B); // RL3
  assign reset_cmd = wr && dif.in_window && dif.bank_low
    && (wbyte == D_RESET); // RL4
  assign id_mode = state == ST_ID;
  assign check_pending = chk;

  // ****************************************************************
  // Sequence state
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_id_sel = id_sel;
    next_last_addr = last_addr;
    next_word_cnt = word_cnt;
    next_chk = 1'b0;
    next_op_start = 1'b0;
    next_op_skip = 1'b0;
    next_op_kind = op_kind;
    next_page_addr = page_addr;
    next_block_num = block_num;
    next_page_num = page_num;
    next_area_sel = area_sel;
    next_pbit_idx = pbit_idx;
    next_swap_idx = swap_idx;
    next_word_valid = 1'b0;
    next_prog_word = prog_word;
    if (chk)
    begin
      // One cycle for the protection logic to judge the operands
      next_op_skip = target_protected; // RL24
      next_op_start = !target_protected; // RL24
    end
    else if (op_busy && state != ST_PROG)
    begin
      // Running operation: every write is dropped here
      next_state = ST_READ; // RL23
    end
    else if (reset_cmd)
    begin
      next_state = ST_READ; // RL21
    end
    else if (wr)
    begin
      next_state = ST_READ; // RL25
      unique case (state)
        ST_READ:
        begin
          if (at_a && wbyte == D_UNLOCK1)
            next_state = ST_U1; // RL5
        end
        ST_U1:
        begin
          if (at_b && wbyte == D_UNLOCK2)
            next_state = ST_U2; // RL5
        end
        ST_U2:
        begin
          next_cmd = wbyte;
          if (at_a && wbyte == D_IDREAD)
          begin
            next_state = ST_ID; // RL6
            next_id_sel = IDC_MFR;
          end
          else if (at_a && wbyte == D_PROG)
            next_state = ST_TARGET; // RL8
          else if (at_a && wbyte == D_ERASE)
            next_state = ST_E1; // RL10
          else if (at_a && (wbyte == D_PBIT || wbyte == D_PERASE))
            next_state = ST_C4; // RL15 RL17
        end
        ST_ID:
        begin
          if (dif.in_window && dif.bank_low && wbyte == D_IDSEL)
          begin
            next_state = ST_ID; // RL22
            next_id_sel = dif.id_sel; // RL7
          end
        end
        ST_TARGET:
        begin
          if (dif.in_window)
          begin
            next_state = ST_PROG;
            next_op_kind = OP_PROG;
            next_op_start = 1'b1; // RL8
            next_page_addr = dif.page_addr; // RL9
            next_last_addr = bus_addr;
            next_word_cnt = 2'h0;
            next_word_valid = 1'b1;
            next_prog_word = bus_wdata;
          end
        end
        ST_PROG:
        begin
          // Each word must sit exactly one word step above the last
          if (bus_addr == last_addr + WORD_STEP) // RL8
          begin
            next_last_addr = bus_addr;
            next_word_cnt = word_cnt + 2'h1;
            next_word_valid = 1'b1;
            next_prog_word = bus_wdata;
            if (word_cnt != PROG_WORDS - 2'h1)
              next_state = ST_PROG;
          end
        end
        ST_E1:
        begin
          if (at_a && wbyte == D_UNLOCK1)
            next_state = ST_E2; // RL10
        end
        ST_E2:
        begin
          if (at_b && wbyte == D_UNLOCK2)
            next_state = ST_E3; // RL10
        end
        ST_E3:
        begin
          next_block_num = dif.block_num; // RL12 RL14
          next_page_num = dif.page_num; // RL13
          next_area_sel = dif.area_sel; // RL11 RL14
          if (at_a && wbyte == SEL_CHIP)
          begin
            next_op_kind = OP_CHIP; // RL10
            next_chk = 1'b1;
          end
          else if (dif.in_window && wbyte == SEL_AREA)
          begin
            next_op_kind = OP_AREA; // RL11
            next_chk = 1'b1;
          end
          else if (dif.in_window && wbyte == SEL_BLOCK)
          begin
            next_op_kind = OP_BLOCK; // RL12
            next_chk = 1'b1;
          end
          else if (dif.in_window && wbyte == SEL_PAGE)
          begin
            next_op_kind = OP_PAGE; // RL13
            next_chk = 1'b1;
          end
        end
        ST_C4:
        begin
          // Swap wins on its own address pattern whatever byte opened it
          if (wbyte == D_PBIT && dif.swap_ok)
          begin
            next_op_kind = OP_SWAP; // RL26 RL18
            next_swap_idx = dif.swap_idx; // RL19
            next_op_start = 1'b1;
          end
          else if (cmd == D_PBIT && wbyte == D_PBIT && dif.pbit_ok)
          begin
            next_op_kind = OP_PBIT_PROG; // RL15 RL16
            next_pbit_idx = dif.pbit_idx;
            next_op_start = 1'b1;
          end
          else if (cmd == D_PERASE && wbyte == D_PERASE
                   && dif.in_window && dif.bank_low)
          begin
            next_op_kind = OP_PBIT_ERASE; // RL17
            next_op_start = 1'b1;
          end
        end
        default:
        begin
          next_state = ST_READ;
        end
      endcase
    end
  end

  // ****************************************************************
  // Identification code read
  // ****************************************************************
  always_comb
  begin
    next_code_valid = rd && id_mode && dif.in_window; // RL6
    next_code = code_rdata;
    if (next_code_valid)
    begin
      unique case (id_sel) // RL7
        IDC_MFR: next_code = ID_CODE_MFR;
        IDC_DEV: next_code = ID_CODE_DEV;
        IDC_MACRO: next_code = ID_CODE_MACRO;
        default: next_code = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_READ;
      cmd <= 8'h00;
      id_sel <= IDC_MFR;
      last_addr <= 32'h0000_0000;
      word_cnt <= 2'h0;
      chk <= 1'b0;
      op_start <= 1'b0;
      op_skip <= 1'b0;
      op_kind <= OP_PROG;
      page_addr <= 16'h0000;
      block_num <= 6'h00;
      page_num <= 7'h00;
      area_sel <= 1'b0;
      pbit_idx <= 8'h00;
      swap_idx <= 4'h0;
      prog_word_valid <= 1'b0;
      prog_word <= 32'h0000_0000;
      code_rdata <= 8'h00;
      code_rvalid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      id_sel <= next_id_sel;
      last_addr <= next_last_addr;
      word_cnt <= next_word_cnt;
      chk <= next_chk;
      op_start <= next_op_start;
      op_skip <= next_op_skip;
      op_kind <= next_op_kind;
      page_addr <= next_page_addr;
      block_num <= next_block_num;
      page_num <= next_page_num;
      area_sel <= next_area_sel;
      pbit_idx <= next_pbit_idx;
      swap_idx <= next_swap_idx;
      prog_word_valid <= next_word_valid;
      prog_word <= next_prog_word;
      code_rdata <= next_code;
      code_rvalid <= next_code_valid;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_reset_to_read: assert property ( // RL4
    reset_cmd && !chk && !op_busy |=> state == ST_READ && !op_start)
    else $error("read/reset did not return to read mode");
  a_busy_drops_seq: assert property ( // RL23
    op_busy && state == ST_READ && !chk |=> state == ST_READ && !op_start)
    else $error("sequence advanced during a running operation");
  a_protect_skip: assert property ( // RL24
    chk && target_protected |=> op_skip && !op_start ##1 !op_skip)
    else $error("protected erase target was not skipped");
  a_id_holds: assert property ( // RL22
    id_mode && !bus_req && !chk && !op_busy |=> id_mode)
    else $error("code read mode left without read/reset");
  a_code_answer: assert property ( // RL6
    rd && id_mode && dif.in_window |=> code_rvalid
      ##1 (!code_rvalid || $past(rd)))
    else $error("code read not answered next cycle");
  a_narrow_ignore: assert property ( // RL1
    bus_req && bus_we && !bus_word && !chk && !op_busy
      && state != ST_PROG |=> $stable(state))
    else $error("narrow write advanced the sequence");
  a_bad_unlock: assert property ( // RL25
    state == ST_U1 && wr && !(at_b && wbyte == D_UNLOCK2) && !op_busy
      |=> state == ST_READ)
    else $error("mismatching write did not abandon the sequence");
  a_prog_first_word: assert property ( // RL8
    op_start && op_kind == OP_PROG |-> prog_word_valid && id_mode == 1'b0)
    else $error("program start without its first word");
  a_swap_range: assert property ( // RL19
    op_start && op_kind == OP_SWAP |-> swap_idx < SWAP_COUNT[3:0])
    else $error("swap bit index out of range");
  a_erase_checked: assert property ( // RL10
    op_start && (op_kind == OP_CHIP || op_kind == OP_BLOCK
      || op_kind == OP_AREA || op_kind == OP_PAGE) |-> $past(chk))
    else $error("erase started without protection check");
endmodule

// ### testbench/fcs_cpu_model.sv
// Processor bus master model issuing command writes and code reads
`timescale 1ns/1ps
module fcs_cpu_model
(
  input wire logic ref_clk,
  output logic bus_req,
  output logic bus_we,
  output logic bus_word,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata
);
  initial
  begin
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_word = 1'b0;
    bus_addr = 32'h0000_0000;
    bus_wdata = 32'h0000_0000;
  end

  // ****************************************************************
  // Transfers
  // ****************************************************************
  // Launched on the falling edge, held until the next one
  task automatic xfer(input logic we, input logic word,
    input logic [31:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    bus_req = 1'b1;
    bus_we = we;
    bus_word = word;
    bus_addr = a;
    bus_wdata = d;
  endtask

  // Command value rides in the low byte of a full word
  task automatic wb(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [31:0] a);
    xfer(1'b0, 1'b1, a, ~bus_wdata);
  endtask

  // Released lines show the inverse so a stale value cannot pass
  task automatic idle();
    @(negedge ref_clk);
    bus_req = 1'b0;
    bus_we = ~bus_we;
    bus_word = ~bus_word;
    bus_addr = ~bus_addr;
    bus_wdata = ~bus_wdata;
  endtask
endmodule

// ### testbench/fcs_sequencer_bench.sv
// Self-checking bench of the flash command sequence decoder
`timescale 1ns/1ps
module fcs_sequencer_bench;
  import fcs_pkg::*;
  localparam logic [7:0] ID_MFR = 8'h4B; // Arbitrary value
  localparam logic [7:0] ID_DEV = 8'hB4; // Arbitrary value
  localparam logic [7:0] ID_MAC = 8'h69; // Arbitrary value
  localparam logic [31:0] U54 = 32'h5E00_5400;
  localparam logic [31:0] UAA = 32'h5E00_AA00;
  localparam logic [31:0] BASE = 32'h5E00_0000;
  logic ref_clk, rst, bus_req, bus_we, bus_word, op_busy, target_protected;
  logic [31:0] bus_addr, bus_wdata, prog_word;
  logic [7:0] code_rdata, pbit_idx;
  logic code_rvalid, id_mode, check_pending, op_start, op_skip;
  logic area_sel, prog_word_valid;
  fcs_op_e op_kind;
  logic [15:0] page_addr;
  logic [5:0] block_num;
  logic [6:0] page_num;
  logic [3:0] swap_idx;
  int n_fail = 0;
  int comparisons = 0;

  fcs_sequencer #(.ID_CODE_MFR(ID_MFR), .ID_CODE_DEV(ID_DEV),
    .ID_CODE_MACRO(ID_MAC)) dut (.ref_clk(ref_clk), .rst(rst),
    .bus_req(bus_req), .bus_we(bus_we), .bus_word(bus_word),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .op_busy(op_busy),
    .target_protected(target_protected), .code_rdata(code_rdata),
    .code_rvalid(code_rvalid), .id_mode(id_mode),
    .check_pending(check_pending), .op_start(op_start),
    .op_skip(op_skip), .op_kind(op_kind), .page_addr(page_addr),
    .block_num(block_num), .page_num(page_num), .area_sel(area_sel),
    .pbit_idx(pbit_idx), .swap_idx(swap_idx),
    .prog_word_valid(prog_word_valid), .prog_word(prog_word));

  fcs_cpu_model cpu (.ref_clk(ref_clk), .bus_req(bus_req),
    .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic unlock(input logic [7:0] c);
    cpu.wb(U54, D_UNLOCK1);
    cpu.wb(UAA, D_UNLOCK2);
    cpu.wb(U54, c);
  endtask

  // Two unlock writes at chosen places, then ID select
  task automatic idtry(input logic [31:0] a1, input logic [31:0] a2);
    cpu.wb(a1, D_UNLOCK1);
    cpu.wb(a2, D_UNLOCK2);
    cpu.wb(U54, D_IDREAD);
    cpu.wb(BASE, D_IDSEL);
    cpu.idle();
  endtask

  task automatic reset_cmd();
    cpu.wb(BASE, D_RESET);
    cpu.idle();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic erase(input logic [7:0] sel, input logic [31:0] a,
    input logic prot, input fcs_op_e kind);
    unlock(D_ERASE);
    cpu.wb(U54, D_UNLOCK1);
    cpu.wb(UAA, D_UNLOCK2);
    cpu.wb(a, sel);
    cpu.idle();
    target_protected = prot;
    chk(check_pending, 1'b1);
    chk(op_kind, kind);
    @(negedge ref_clk);
    target_protected = 1'b0;
    chk(op_start, !prot);
    chk(op_skip, prot);
    chk(check_pending, 1'b0);
  endtask

  task automatic t_erase();
    erase(SEL_CHIP, U54, 1'b0, OP_CHIP);
    erase(SEL_AREA, 32'h5E08_0000, 1'b0, OP_AREA);
    chk(area_sel, 1'b1);
    erase(SEL_AREA, BASE, 1'b0, OP_AREA);
    chk(area_sel, 1'b0);
    erase(SEL_BLOCK, 32'h5E05_7234, 1'b0, OP_BLOCK);
    chk(block_num, 6'h2B);
    erase(SEL_PAGE, 32'h5E05_D0FC, 1'b0, OP_PAGE);
    chk(page_num, 7'h5D);
    erase(SEL_BLOCK, 32'h5E03_E000, 1'b1, OP_BLOCK);
    chk(block_num, 6'h1F);
    $display("erase test done");
  endtask

  task automatic t_prog();
    logic [31:0] pa;
    pa = 32'h5E0A_BC40;
    // Clock never leaves normal mode here, so it counts as stable
    unlock(D_PROG);
    for (int i = 0; i < 4; i++)
    begin
      cpu.xfer(1'b1, 1'b1, pa + WORD_STEP * 32'(i), 32'hC0DE_0000 + 32'(i));
      if (i > 0)
      begin
        chk(op_start, i == 1);
        chk(prog_word_valid, 1'b1);
        chk(prog_word, 32'hC0DE_0000 + 32'(i - 1));
      end
      if (i == 1)
      begin
        chk(op_kind, OP_PROG);
        chk(page_addr, pa[18:3]);
      end
    end
    cpu.idle();
    chk(prog_word, 32'hC0DE_0003);
    @(negedge ref_clk);
    chk(prog_word_valid, 1'b0);
    $display("program test done");
  endtask

  task automatic t_id();
    logic [7:0] exp [4];
    exp = '{ID_MFR, ID_DEV, 8'h00, ID_MAC};
    unlock(D_IDREAD);
    for (int s = 0; s < 4; s++)
    begin
      cpu.wb(BASE | (32'(s) << 14), D_IDSEL);
      cpu.rd(32'h5E07_FFF0);
      cpu.idle();
      chk(code_rvalid, 1'b1);
      chk(code_rdata, exp[s]);
      chk(id_mode, 1'b1);
    end
    reset_cmd();
    chk(id_mode, 1'b0);
    cpu.rd(32'h5E07_FFF0);
    cpu.idle();
    chk(code_rvalid, 1'b0);
    $display("id test done");
  endtask

  task automatic four(input logic [7:0] c3, input logic [7:0] d4,
    input logic [31:0] a4, input fcs_op_e kind);
    unlock(c3);
    cpu.wb(a4, d4);
    cpu.idle();
    chk(op_start, 1'b1);
    chk(op_kind, kind);
    @(negedge ref_clk);
    chk(op_start, 1'b0);
  endtask

  task automatic t_four();
    four(D_PBIT, D_PBIT, 32'h5E00_0260, OP_PBIT_PROG);
    chk(pbit_idx, 8'h26);
    four(D_PBIT, D_PBIT, 32'h5E00_0070, OP_PBIT_PROG);
    chk(pbit_idx, 8'h07);
    four(D_PERASE, D_PERASE, BASE, OP_PBIT_ERASE);
    four(D_PBIT, D_PBIT, 32'h5E00_0880, OP_SWAP);
    chk(swap_idx, 4'h0);
    four(D_PERASE, D_PBIT, 32'h5E00_0920, OP_SWAP);
    chk(swap_idx, 4'hA);
    $display("protect and swap test done");
  endtask

  task automatic t_abort();
    // Narrow write carries the right byte but must not advance
    cpu.wb(U54, D_UNLOCK1);
    cpu.xfer(1'b1, 1'b0, UAA, 32'h0000_0055);
    cpu.wb(UAA, D_UNLOCK2);
    cpu.wb(U54, D_IDREAD);
    cpu.wb(BASE, D_IDSEL);
    cpu.idle();
    chk(id_mode, 1'b1);
    reset_cmd();
    idtry(U54, U54);
    chk(id_mode, 1'b0);
    idtry(32'h5E10_5400, UAA);
    chk(id_mode, 1'b0);
    cpu.wb(U54, D_UNLOCK1);
    cpu.wb(UAA, D_UNLOCK2);
    cpu.wb(BASE, D_RESET);
    cpu.wb(U54, D_IDREAD);
    cpu.wb(BASE, D_IDSEL);
    cpu.idle();
    chk(id_mode, 1'b0);
    op_busy = 1'b1;
    unlock(D_PERASE);
    cpu.wb(BASE, D_PERASE);
    cpu.idle();
    chk(op_start, 1'b0);
    @(negedge ref_clk);
    chk(op_start, 1'b0);
    op_busy = 1'b0;
    $display("abort test done");
  endtask

  // ****************************************************************
  // Clock, reset and run
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    #400000;
    n_fail++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    op_busy = 1'b0;
    target_protected = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    t_erase();
    t_prog();
    t_id();
    t_four();
    t_abort();
    end_of_test();
  end
endmodule
